// ---- hdl/mtx_defines.svh ----
// constants for the mii transmit mac port
`ifndef MTX_DEFINES_SVH
`define MTX_DEFINES_SVH

// ------------------------------------------------------------
// buffer occupancy
// ------------------------------------------------------------
`define MTX_BUF_FULL 2'd2
`define MTX_BUF_EMPTY 2'd0

// ------------------------------------------------------------
// nibble patterns on the transmit pins
// ------------------------------------------------------------
`define MTX_IDLE_NIB 4'h0
`define MTX_PRE_NIB 4'h5
`define MTX_SFD_NIB 4'hd
`define MTX_JAM_NIB 4'h5

// ------------------------------------------------------------
// nibble counts (index of the last nibble of each phase)
// ------------------------------------------------------------
`define MTX_SFD_AT 5'd14
`define MTX_PRE_LAST 5'd15
`define MTX_JAM_LAST 5'd7
`define MTX_IFG_LAST 5'd23

// ------------------------------------------------------------
// retry and backoff
// ------------------------------------------------------------
`define MTX_ATT_LIMIT 5'd16
`define MTX_ATT_NONE 5'd0
`define MTX_BACKOFF_CAP 10
`define MTX_SLOT_PAD 7'h00
`define MTX_LFSR_SEED 16'hace1

// ------------------------------------------------------------
// event bit positions
// ------------------------------------------------------------
`define MTX_EV_DONE 0
`define MTX_EV_RETRY 1
`define MTX_EV_ABORT 2
`define MTX_EV_UNDERRUN 3

`endif

// ---- hdl/mtx_pkg.sv ----
// types shared by the mii transmit mac port
package mtx_pkg;

   // ------------------------------------------------------------
   // link side sequencer states
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      ls_idle  = 7'h01,
      ls_pre   = 7'h02,
      ls_data  = 7'h04,
      ls_jam   = 7'h08,
      ls_drain = 7'h10,
      ls_back  = 7'h20,
      ls_ifg   = 7'h40
   } mtx_lstate_t;

   // ------------------------------------------------------------
   // two-entry buffer state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0][8:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
      logic in_ready;
      logic out_valid;
   } mtx_buf_t;

   // ------------------------------------------------------------
   // system clock domain state
   // ------------------------------------------------------------
   typedef struct packed {
      logic ack_meta;
      logic ack_s;
      logic [3:0] ev_meta;
      logic [3:0] ev_s;
      logic [3:0] ev_d;
      logic [3:0] ev_pulse;
      logic req;
      logic [7:0] hold_data;
      logic hold_last;
      logic dma_tx;
      logic dma_rx;
      logic [1:0] mode;
   } mtx_sys_t;

   // ------------------------------------------------------------
   // link clock domain state
   // ------------------------------------------------------------
   typedef struct packed {
      logic rst_meta;
      logic rst;
      logic col_meta;
      logic col_s;
      logic crs_meta;
      logic crs_s;
      logic dup_meta;
      logic dup_s;
      logic req_meta;
      logic req_s;
      logic ack;
      mtx_lstate_t state;
      logic [4:0] cnt;
      logic half;
      logic [7:0] byte_q;
      logic last_q;
      logic got_last;
      logic [4:0] attempts;
      logic [16:0] back;
      logic [15:0] lfsr;
      logic [3:0] txd;
      logic tx_en;
      logic [3:0] ev_tog;
   } mtx_link_t;

endpackage

// ---- hdl/mtx_buf.sv ----
// two-entry valid/ready buffer for transmit bytes
`timescale 1ns/1ps
`include "mtx_defines.svh"

module mtx_buf
   import mtx_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // filling side
   input wire logic [8:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // draining side
   output logic [8:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   mtx_buf_t s;
   mtx_buf_t next_s;
   logic push;
   logic pop;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // ready and valid are kept as flops so neither side sees a comb path
   always_comb begin
      next_s = s;
      push = in_valid & s.in_ready;
      pop = out_ready & s.out_valid;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = ~s.wp;
      end
      if (pop) begin
         next_s.rp = ~s.rp;
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + 2'd1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 2'd1;
      end
      next_s.in_ready = (next_s.cnt != `MTX_BUF_FULL);
      next_s.out_valid = (next_s.cnt != `MTX_BUF_EMPTY);
      if (srst) begin
         next_s = '0;
         next_s.in_ready = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      s <= next_s;
   end

   // outputs straight from the state
   assign in_ready = s.in_ready;
   assign out_valid = s.out_valid;
   assign out_data = s.mem[s.rp];

endmodule

// ---- hdl/mtx_top.sv ----
// transmit mac port: byte stream in, mii nibbles out on the phy clock
`timescale 1ns/1ps
`include "mtx_defines.svh"

// Operation
// - phy supplies continuous tx clock, 2.5 or 25 MHz; all mii tx outputs timed by it
// - nibble per tx clock, bit 0 least significant, low nibble of byte first
// - nibble lines only meaningful while transmit enable is high
// - transmit enable driven on tx clock, high exactly while nibbles are presented
// - collision input synchronised before any clocked logic uses it
// - full duplex collision pauses new frames, a running frame finishes
// - four line modes: full or half duplex at 100 or 10 Mb/s
// - transmit dma request raised whenever the transmit buffer is empty
// - receive dma request raised on packet receipt, separate from transmit
module mtx_top
   import mtx_pkg::*;
(
   // system clock and reset
   input wire logic clk,
   input wire logic srst,
   // transmit byte stream
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_valid,
   output logic tx_ready,
   // line configuration
   input wire logic full_duplex,
   input wire logic speed_100,
   output logic [1:0] line_mode,
   // dma requests
   input wire logic rx_packet_received,
   input wire logic rx_dma_ack,
   output logic tx_dma_req,
   output logic rx_dma_req,
   // transmit events, one-cycle pulses
   output logic tx_frame_done,
   output logic tx_retry,
   output logic tx_excess_abort,
   output logic tx_underrun,
   // mii transmit side
   input wire logic phy_transmit_clock_in,
   output logic [3:0] transmit_nibble_out,
   output logic transmit_nibble_valid_out,
   input wire logic collision_in,
   input wire logic carrier_sense_in
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   mtx_sys_t c;
   mtx_sys_t next_c;
   mtx_link_t l;
   mtx_link_t next_l;
   logic [8:0] buf_data;
   logic buf_valid;
   logic buf_take;
   logic buf_in_ready;
   logic pend;
   logic coll;
   logic blocked;
   logic emit;
   logic jam_start;

   // backoff window: 2^min(n,cap)-1 slots for attempt n
   function automatic logic [9:0] mtx_window(input logic [4:0] n);
      logic [9:0] m;
      m = '0;
      for (int i = 0; i < `MTX_BACKOFF_CAP; i++) begin
         m[i] = (5'(i) < n);
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // transmit buffer
   // ------------------------------------------------------------
   // two words absorb the handshake turnaround; a stall upstream loses nothing
   mtx_buf u_buf (
      .clk(clk),
      .srst(srst),
      .in_data({tx_last, tx_data}),
      .in_valid(tx_valid),
      .in_ready(buf_in_ready),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(buf_take)
   );

   // byte moves to the hold register only when the link has acknowledged the last
   assign buf_take = buf_valid & (c.ack_s == c.req);

   // ------------------------------------------------------------
   // system clock domain
   // ------------------------------------------------------------
   // hold register plus req/ack toggles form the byte handshake
   always_comb begin
      next_c = c;
      // ack toggle from the link, two flops
      next_c.ack_meta = l.ack;
      next_c.ack_s = c.ack_meta;
      // event toggles from the link, two flops then edge detect
      next_c.ev_meta = l.ev_tog;
      next_c.ev_s = c.ev_meta;
      next_c.ev_d = c.ev_s;
      next_c.ev_pulse = c.ev_s ^ c.ev_d;
      if (buf_take) begin
         next_c.req = ~c.req;
         next_c.hold_data = buf_data[7:0];
         next_c.hold_last = buf_data[8];
      end
      next_c.dma_tx = ~buf_valid;
      // set wins over the acknowledge
      next_c.dma_rx = rx_packet_received | (c.dma_rx & ~rx_dma_ack);
      next_c.mode = {full_duplex, speed_100};
      if (srst) begin
         next_c = '0;
      end
   end

   // system state register
   always_ff @(posedge clk) begin
      c <= next_c;
   end

   // ------------------------------------------------------------
   // link clock domain: sequencer
   // ------------------------------------------------------------
   // the phy clock runs free, so reset and level syncs may count on its edges
   always_comb begin
      next_l = l;
      emit = 1'b0;
      jam_start = 1'b0;
      // reset from the system domain, two flops
      next_l.rst_meta = srst;
      next_l.rst = l.rst_meta;
      // asynchronous pins and levels, two flops each
      next_l.col_meta = collision_in;
      next_l.col_s = l.col_meta;
      next_l.crs_meta = carrier_sense_in;
      next_l.crs_s = l.crs_meta;
      next_l.dup_meta = c.mode[1];
      next_l.dup_s = l.dup_meta;
      next_l.req_meta = c.req;
      next_l.req_s = l.req_meta;
      // free running pseudo random source for the backoff draw
      next_l.lfsr = {l.lfsr[14:0], l.lfsr[15] ^ l.lfsr[13] ^ l.lfsr[12] ^ l.lfsr[10]};
      pend = (l.req_s != l.ack);
      coll = ~l.dup_s & l.col_s;
      // full duplex: collision is flow control; half duplex: defer to carrier
      blocked = l.dup_s ? l.col_s : l.crs_s;

      case (l.state)
         ls_idle: begin
            next_l.tx_en = 1'b0;
            next_l.txd = `MTX_IDLE_NIB;
            // only start checks the pause, so the pause never stops a running frame
            if (pend && !blocked) begin
               next_l.state = ls_pre;
               next_l.cnt = '0;
               next_l.half = 1'b0;
               next_l.last_q = 1'b0;
               next_l.got_last = 1'b0;
               next_l.txd = `MTX_PRE_NIB;
               next_l.tx_en = 1'b1;
            end
         end
         ls_pre: begin
            if (coll) begin
               jam_start = 1'b1;
            end else if (l.cnt == `MTX_PRE_LAST) begin
               emit = 1'b1;
            end else begin
               next_l.cnt = l.cnt + 5'd1;
               next_l.txd = (l.cnt == `MTX_SFD_AT) ? `MTX_SFD_NIB : `MTX_PRE_NIB;
            end
         end
         ls_data: begin
            if (coll) begin
               jam_start = 1'b1;
            end else begin
               emit = 1'b1;
            end
         end
         ls_jam: begin
            if (l.cnt == `MTX_JAM_LAST) begin
               next_l.tx_en = 1'b0;
               next_l.txd = `MTX_IDLE_NIB;
               // slots of 128 nibbles, window truncated at ten doublings
               next_l.back = {mtx_window(l.attempts) & l.lfsr[9:0], `MTX_SLOT_PAD};
               next_l.state = l.got_last ? ls_back : ls_drain;
            end else begin
               next_l.cnt = l.cnt + 5'd1;
            end
         end
         ls_drain: begin
            // discard the rest of an aborted frame so the next one starts clean
            if (pend) begin
               next_l.ack = ~l.ack;
               if (c.hold_last) begin
                  next_l.cnt = '0;
                  next_l.state = (l.attempts == `MTX_ATT_NONE) ? ls_ifg : ls_back;
               end
            end
         end
         ls_back: begin
            if (l.attempts == `MTX_ATT_LIMIT) begin
               next_l.ev_tog[`MTX_EV_ABORT] = ~l.ev_tog[`MTX_EV_ABORT];
               next_l.attempts = `MTX_ATT_NONE;
               next_l.cnt = '0;
               next_l.state = ls_ifg;
            end else if (l.back == '0) begin
               // the source replays the frame after this pulse
               next_l.ev_tog[`MTX_EV_RETRY] = ~l.ev_tog[`MTX_EV_RETRY];
               next_l.cnt = '0;
               next_l.state = ls_ifg;
            end else begin
               next_l.back = l.back - 17'h00001;
            end
         end
         ls_ifg: begin
            if (l.cnt == `MTX_IFG_LAST) begin
               next_l.state = ls_idle;
            end else begin
               next_l.cnt = l.cnt + 5'd1;
            end
         end
         default: begin
            next_l.state = ls_idle;
            next_l.tx_en = 1'b0;
         end
      endcase

      // ------------------------------------------------------------
      // jam entry
      // ------------------------------------------------------------
      if (jam_start) begin
         next_l.state = ls_jam;
         next_l.cnt = '0;
         next_l.txd = `MTX_JAM_NIB;
         next_l.tx_en = 1'b1;
         next_l.attempts = l.attempts + 5'd1;
      end

      // ------------------------------------------------------------
      // data nibble emission
      // ------------------------------------------------------------
      // one byte is fetched per two nibbles, low half first
      if (emit) begin
         next_l.state = ls_data;
         if (l.half) begin
            next_l.half = 1'b0;
            next_l.txd = l.byte_q[7:4];
         end else if (l.last_q) begin
            // last byte fully shown: drop enable with the data
            next_l.tx_en = 1'b0;
            next_l.txd = `MTX_IDLE_NIB;
            next_l.attempts = `MTX_ATT_NONE;
            next_l.ev_tog[`MTX_EV_DONE] = ~l.ev_tog[`MTX_EV_DONE];
            next_l.cnt = '0;
            next_l.state = ls_ifg;
         end else if (pend) begin
            next_l.ack = ~l.ack;
            next_l.byte_q = c.hold_data;
            next_l.last_q = c.hold_last;
            next_l.got_last = c.hold_last;
            next_l.txd = c.hold_data[3:0];
            next_l.tx_en = 1'b1;
            next_l.half = 1'b1;
         end else begin
            // the source fell behind the wire; the frame cannot be paused
            next_l.tx_en = 1'b0;
            next_l.txd = `MTX_IDLE_NIB;
            next_l.attempts = `MTX_ATT_NONE;
            next_l.ev_tog[`MTX_EV_UNDERRUN] = ~l.ev_tog[`MTX_EV_UNDERRUN];
            next_l.state = ls_drain;
         end
      end

      // ------------------------------------------------------------
      // link reset
      // ------------------------------------------------------------
      if (l.rst) begin
         next_l.state = ls_idle;
         next_l.ack = 1'b0;
         next_l.cnt = '0;
         next_l.half = 1'b0;
         next_l.byte_q = '0;
         next_l.last_q = 1'b0;
         next_l.got_last = 1'b0;
         next_l.attempts = `MTX_ATT_NONE;
         next_l.back = '0;
         next_l.lfsr = `MTX_LFSR_SEED;
         next_l.txd = `MTX_IDLE_NIB;
         next_l.tx_en = 1'b0;
         next_l.ev_tog = '0;
      end
   end

   // link state register, clocked by the phy transmit clock
   always_ff @(posedge phy_transmit_clock_in) begin
      l <= next_l;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign tx_ready = buf_in_ready;
   assign line_mode = c.mode;
   assign tx_dma_req = c.dma_tx;
   assign rx_dma_req = c.dma_rx;
   assign tx_frame_done = c.ev_pulse[`MTX_EV_DONE];
   assign tx_retry = c.ev_pulse[`MTX_EV_RETRY];
   assign tx_excess_abort = c.ev_pulse[`MTX_EV_ABORT];
   assign tx_underrun = c.ev_pulse[`MTX_EV_UNDERRUN];
   assign transmit_nibble_out = l.txd;
   assign transmit_nibble_valid_out = l.tx_en;

endmodule

// ---- verification/mtx_top_assertions.sv ----
// concurrent checks on the pins of the transmit mac port
`timescale 1ns/1ps
module mtx_top_checker (
   // system side
   input wire logic clk,
   input wire logic srst,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic full_duplex,
   input wire logic speed_100,
   input wire logic [1:0] line_mode,
   input wire logic rx_packet_received,
   input wire logic rx_dma_ack,
   input wire logic tx_dma_req,
   input wire logic rx_dma_req,
   input wire logic tx_frame_done,
   input wire logic tx_retry,
   // mii side
   input wire logic phy_transmit_clock_in,
   input wire logic [3:0] transmit_nibble_out,
   input wire logic transmit_nibble_valid_out,
   input wire logic collision_in
);
   logic en;
   logic [3:0] nib;
   // short names keep the link properties readable
   assign en = transmit_nibble_valid_out;
   assign nib = transmit_nibble_out;
   // ------------------------------------------------------------
   // system clock domain
   // ------------------------------------------------------------
   a_line_mode_follow: assert property (@(posedge clk) disable iff (srst)
      !$past(srst) |-> line_mode == $past({full_duplex, speed_100})) else $error("line mode stale");
   a_dma_empty_ready: assert property (@(posedge clk) disable iff (srst)
      tx_dma_req |-> tx_ready) else $error("dma request with buffer not empty");
   a_dma_req_drop: assert property (@(posedge clk) disable iff (srst)
      tx_valid && tx_ready |-> ##2 !tx_dma_req) else $error("dma request kept after a byte");
   a_rx_req_set: assert property (@(posedge clk) disable iff (srst)
      rx_packet_received |=> rx_dma_req) else $error("receive request not raised");
   a_rx_req_clear: assert property (@(posedge clk) disable iff (srst)
      rx_dma_ack && !rx_packet_received |=> !rx_dma_req) else $error("receive request not cleared");
   // ------------------------------------------------------------
   // link clock domain
   // ------------------------------------------------------------
   a_idle_nibble_zero: assert property (@(posedge phy_transmit_clock_in) disable iff (srst)
      !en |-> nib == 4'h0) else $error("nibble lines busy without enable");
   a_preamble_order: assert property (@(posedge phy_transmit_clock_in) disable iff (srst)
      $rose(en) && full_duplex |-> (en && nib == 4'h5)[*8] ##1 (en && nib == 4'h5)[*7]
      ##1 (en && nib == 4'hd)) else $error("bad preamble or delimiter");
   a_pause_no_start: assert property (@(posedge phy_transmit_clock_in) disable iff (srst)
      (full_duplex && collision_in)[*5] ##0 !en |=> !en) else $error("frame started while paused");
   a_jam_then_stop: assert property (@(posedge phy_transmit_clock_in) disable iff (srst)
      !full_duplex && en && collision_in |-> ##[1:16] !en) else $error("no stop after collision");
   // main scenarios seen
   c_frame_start: cover property (@(posedge phy_transmit_clock_in) disable iff (srst) $rose(en));
   c_frame_done: cover property (@(posedge clk) disable iff (srst) tx_frame_done);
   c_retry: cover property (@(posedge clk) disable iff (srst) tx_retry);
endmodule

// ---- verification/mtx_phy_model.sv ----
// behavioural phy at the far side of the mii transmit pins
`timescale 1ns/1ps
module mtx_phy_model (
   // commands from the bench
   input wire logic rst,
   input wire logic fd,
   input wire logic col_cmd,
   input wire logic crs_cmd,
   // mii transmit side
   output logic phy_clk,
   input wire logic [3:0] nib,
   input wire logic en,
   output logic col,
   output logic crs,
   // what was captured
   output int frames,
   output int len,
   output logic [7:0] rbyte,
   output logic pre_bad
);
   logic en_q;
   // free running clock, own phase; never stops between frames
   initial begin
      phy_clk = 1'b0;
      #37;
      forever #62.5 phy_clk = ~phy_clk;
   end
   // nibbles are taken only while enable is high, low nibble first
   always @(posedge phy_clk) begin
      if (rst) begin
         {col, crs, en_q, pre_bad, rbyte} <= '0;
         frames <= 0;
         len <= 0;
      end else begin
         col <= col_cmd;
         // carrier only in half duplex; held low in full duplex
         crs <= ~fd & (crs_cmd | col_cmd | en);
         en_q <= en;
         if (en) begin
            rbyte <= {nib, rbyte[7:4]};
            len <= en_q ? len + 1 : 1;
            if (!en_q) begin
               pre_bad <= (nib != 4'h5);
            end else if ((len < 15 && nib != 4'h5) || (len == 15 && nib != 4'hd)) begin
               pre_bad <= 1'b1;
            end
         end else if (en_q) begin
            frames <= frames + 1;
         end
      end
   end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the transmit mac port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   import mtx_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] tx_data = 8'h00;
   logic tx_last = 1'b0, tx_valid = 1'b0, full_duplex = 1'b1, speed_100 = 1'b1;
   logic rx_packet_received = 1'b0, rx_dma_ack = 1'b0, col_cmd = 1'b0, crs_cmd = 1'b0;
   logic tx_ready, tx_dma_req, rx_dma_req, tx_frame_done, tx_retry, pre_bad;
   logic tx_underrun, tx_excess_abort;
   int n_under = 0;
   int n_abort = 0;
   logic phy_transmit_clock_in, transmit_nibble_valid_out, collision_in, carrier_sense_in;
   logic [1:0] line_mode;
   logic [3:0] transmit_nibble_out;
   logic [7:0] rbyte;
   int frames, len, f0;
   int err_total = 0;
   int n_checks = 0;
   always #50 clk = ~clk;
   // ------------------------------------------------------------
   // design and far side
   // ------------------------------------------------------------
   mtx_top mtx_top_inst (.clk, .srst, .tx_data, .tx_last, .tx_valid, .tx_ready, .full_duplex, .speed_100,
      .line_mode, .rx_packet_received, .rx_dma_ack, .tx_dma_req, .rx_dma_req, .tx_frame_done, .tx_retry,
      .tx_excess_abort, .tx_underrun, .phy_transmit_clock_in, .transmit_nibble_out,
      .transmit_nibble_valid_out, .collision_in, .carrier_sense_in);
   mtx_phy_model mtx_phy_model_inst (.rst(srst), .fd(full_duplex), .col_cmd, .crs_cmd, .phy_clk(phy_transmit_clock_in),
      .nib(transmit_nibble_out), .en(transmit_nibble_valid_out), .col(collision_in), .crs(carrier_sense_in),
      .frames, .len, .rbyte, .pre_bad);
   // event pulses last one clock; count them as they pass
   always @(posedge clk) begin
      if (tx_underrun === 1'b1) n_under++;
      if (tx_excess_abort === 1'b1) n_abort++;
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one byte; last defaults high, so a plain call is a whole one-byte frame
   task automatic send(input logic [7:0] d, input logic last = 1'b1);
      int i;
      f0 = frames;
      tx_data <= d;
      tx_last <= last;
      tx_valid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (tx_ready === 1'b1) break;
      end
      tx_valid <= 1'b0;
      `CHK("accepted", 1'b1, i < 50)
   endtask
   // sel 0 frame done, 1 retry, 2 enable on the wire, 3 underrun
   task automatic wait_on(input int sel, input int lim);
      int i;
      logic s;
      for (i = 0; i < lim; i++) begin
         @(posedge clk);
         s = (sel == 0) ? tx_frame_done : (sel == 1) ? tx_retry : (sel == 3) ? tx_underrun :
            transmit_nibble_valid_out;
         if (s === 1'b1) break;
      end
      if (i == lim) begin
         err_total++;
         $display("wrong value wait %0d expected 1 seen 0", sel);
         results();
      end
   endtask
   task automatic check_frame(input logic [7:0] d);
      `CHK("frame count", f0 + 1, frames)
      `CHK("nibble count", 18, len)
      `CHK("byte", d, rbyte)
      `CHK("preamble", 1'b0, pre_bad)
      `CHK("tx dma", 1'b1, tx_dma_req)
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_modes();
      int m;
      `CHK("tx dma after reset", 1'b1, tx_dma_req)
      `CHK("rx dma after reset", 1'b0, rx_dma_req)
      `CHK("enable after reset", 1'b0, transmit_nibble_valid_out)
      for (m = 0; m < 4; m++) begin
         {full_duplex, speed_100} <= m[1:0];
         tick(2);
         `CHK("line mode", m[1:0], line_mode)
      end
   endtask
   task automatic t_full_duplex();
      logic [7:0] v [2] = '{8'h3c, 8'hc3};
      foreach (v[k]) begin
         send(v[k]);
         wait_on(0, 400);
         check_frame(v[k]);
      end
   endtask
   // collision pauses new frames but lets a running frame finish
   task automatic t_flow_control();
      col_cmd <= 1'b1;
      send(8'h96);
      tick(80);
      `CHK("paused frames", f0, frames)
      `CHK("paused enable", 1'b0, transmit_nibble_valid_out)
      col_cmd <= 1'b0;
      wait_on(0, 400);
      check_frame(8'h96);
      send(8'h69);
      wait_on(2, 200);
      col_cmd <= 1'b1;
      wait_on(0, 400);
      col_cmd <= 1'b0;
      check_frame(8'h69);
   endtask
   // two-byte frame: the byte handshake cannot keep pace with the wire, so it is cut
   task automatic t_underrun();
      send(8'ha5, 1'b0);
      tick(1);
      send(8'h3f);
      wait_on(3, 400);
      tick(1);
      check_frame(8'ha5);
      `CHK("underruns", 1, n_under)
      tick(40);
   endtask
   // carrier defers the start, collision forces jam and a retry
   task automatic t_half_duplex();
      full_duplex <= 1'b0;
      crs_cmd <= 1'b1;
      // let carrier and duplex settle in the link domain before the byte arrives
      tick(4);
      send(8'h5a);
      tick(40);
      `CHK("deferred frames", f0, frames)
      crs_cmd <= 1'b0;
      wait_on(2, 200);
      tick(3);
      col_cmd <= 1'b1;
      tick(6);
      col_cmd <= 1'b0;
      wait_on(1, 3000);
      `CHK("jammed frames", f0 + 1, frames)
      `CHK("jam cut short", 1'b1, len < 16)
      send(8'h5a);
      wait_on(0, 3000);
      check_frame(8'h5a);
      full_duplex <= 1'b1;
   endtask
   // sticky receive request; a new packet wins over a clear
   task automatic t_rx_dma();
      rx_packet_received <= 1'b1;
      tick(1);
      rx_packet_received <= 1'b0;
      tick(4);
      `CHK("rx dma held", 1'b1, rx_dma_req)
      rx_packet_received <= 1'b1;
      rx_dma_ack <= 1'b1;
      tick(1);
      rx_packet_received <= 1'b0;
      tick(1);
      `CHK("rx dma set wins", 1'b1, rx_dma_req)
      tick(1);
      `CHK("rx dma cleared", 1'b0, rx_dma_req)
      rx_dma_ack <= 1'b0;
   endtask
   initial begin
      tick(8);
      srst <= 1'b0;
      tick(6);
      t_reset_modes();
      t_full_duplex();
      t_flow_control();
      t_underrun();
      t_half_duplex();
      t_rx_dma();
      `CHK("aborts", 0, n_abort)
      results();
   end
endmodule
bind mtx_top mtx_top_checker mtx_top_checker_inst (.clk, .srst, .tx_valid, .tx_ready, .full_duplex, .speed_100,
   .line_mode, .rx_packet_received, .rx_dma_ack, .tx_dma_req, .rx_dma_req, .tx_frame_done, .tx_retry,
   .phy_transmit_clock_in, .transmit_nibble_out, .transmit_nibble_valid_out, .collision_in);
